/* File: gp_pins_model.sv */
`timescale 1ns/1ns
`default_nettype none
module gp_pins_model (
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_lvl,
  output logic      [7:0] pin_i
);
  // No pulls: a released pin shows the outside level
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      pin_i[n] = pin_oe[n] ? pin_o[n] : ext_lvl[n];
    end
  end
endmodule
`default_nettype wire

/* File: gp_pkg.sv */
`default_nettype none
package gp_pkg;
  localparam int unsigned PINS = 8;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_DRV      = 6'h00;
  localparam logic [5:0] IDX_DRV_SET  = 6'h01;
  localparam logic [5:0] IDX_DRV_CLR  = 6'h02;
  localparam logic [5:0] IDX_DRV_FLIP = 6'h03;
  localparam logic [5:0] IDX_LVL      = 6'h04;
  localparam logic [5:0] IDX_LVL_SET  = 6'h05;
  localparam logic [5:0] IDX_LVL_CLR  = 6'h06;
  localparam logic [5:0] IDX_LVL_FLIP = 6'h07;
  localparam logic [5:0] IDX_IN       = 6'h08;
  localparam logic [5:0] IDX_IRQ_CTL  = 6'h09;
  localparam logic [5:0] IDX_IRQ_SEL  = 6'h0a;
  localparam logic [5:0] IDX_IRQ_FLG  = 6'h0c;
  localparam logic [5:0] IDX_PIN_CFG  = 6'h10;
  localparam logic [5:0] IDX_MULTI    = 6'h20;
  localparam logic [5:0] IDX_VMAP     = 6'h21;
  localparam logic [5:0] IDX_CKEV     = 6'h22;
  localparam logic [5:0] IDX_VWIN     = 6'h30;
  localparam int unsigned VSLOTS      = 4;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] IRQ_LVL_MASK_W = 2'h3;

  // Input and sense codes
  localparam logic [2:0] ISC_BOTH  = 3'h0;
  localparam logic [2:0] ISC_RISE  = 3'h1;
  localparam logic [2:0] ISC_FALL  = 3'h2;
  localparam logic [2:0] ISC_LOW   = 3'h3;
  localparam logic [2:0] ISC_FORCE = 3'h6;
  localparam logic [2:0] ISC_OFF   = 3'h7;

  // Output and pull codes; bit 2 selects a wired mode, bit 0 wired-and
  localparam int unsigned OPC_WIRED_BIT = 2;
  localparam int unsigned OPC_AND_BIT   = 0;

  // Clock and event output control fields
  localparam int unsigned CKEV_CLK_BIT = 0;
  localparam int unsigned CKEV_EV_BIT  = 1;
  localparam int unsigned CKEV_PIN_LSB = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       rsv;
    logic       inven;
    logic [2:0] opc;
    logic [2:0] isc;
  } gp_pin_cfg_s;

  typedef struct packed {
    logic [7:0]       drv;
    logic [7:0]       lvl;
    logic [7:0]       sync1;
    logic [7:0]       sync2;
    logic [7:0]       sync3;
    logic [7:0]       in_val;
    logic [7:0]       flags;
    logic [1:0]       irq_lvl_cfg;
    logic [7:0]       irq_sel;
    gp_pin_cfg_s [7:0] cfg;
    logic [7:0]       multi;
    logic [3:0]       vmap;
    logic [4:0]       ckev;
    logic             clk_tog;
    logic             ev_q;
    logic [7:0]       pin_o;
    logic [7:0]       pin_oe;
    logic             irq_req;
    logic [1:0]       irq_level;
    logic             aw_have;
    logic [5:0]       aw_idx;
    logic             w_have;
    logic [7:0]       wdata;
    logic             wlane0;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [7:0]       rdata;
    logic [1:0]       rresp;
  } gp_state_s;
endpackage
`default_nettype wire

/* File: gp_port_regs.sv */
// Overview of operation
// R1: Direction bit one makes pin output
// R2: Direction-set alias sets written-one bits
// R3: Direction-clear alias clears written-one bits
// R4: Direction-flip alias inverts written-one bits
// R5: Direction aliases read back direction register
// R6: Output-value bit drives pin high/low
// R7: Output value matters only for outputs
// R8: Output-set alias sets written-one bits
// R9: Output-clear alias clears written-one bits
// R10: Output-flip alias inverts written-one bits
// R11: Output aliases read back output register
// R12: Input register shows enabled pin levels
// R13: Disabled input buffer: no sampling, no level
// R14: Level field enables irq, picks priority
// R15: Software writes zero to reserved control bits
// R16: Source-select bit admits pin to irq
// R17: Sense match sets flag; one clears
// R18: Clock or event zero to chosen pin
// R19: Event stays on pin while it lasts
// R20: Pin config write applies to masked pins
// R21: Virtual port write equals real write
// R22: Four virtual port mappings exist
// R23: Reserved control bits read zero, ignored
`timescale 1ns/1ns
`default_nettype none
module gp_port_regs #(
  parameter logic [1:0] PORT_ID = 2'h0
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  pin_i,
  output logic [7:0]       pin_o,
  output logic [7:0]       pin_oe,
  input  wire logic        event_ch0,
  output logic             irq_req,
  output logic [1:0]       irq_level
);

  gp_pkg::gp_state_s st_reg;
  gp_pkg::gp_state_s st_next;

  // Virtual window index to real register index
  function automatic logic [5:0] map_index(input logic [5:0] idx, input logic [3:0] vmap);
    logic [5:0] res;
    logic [1:0] slot;
    logic [1:0] entry;
    res   = idx;
    slot  = idx[3:2];
    entry = idx[1:0];
    if (idx >= gp_pkg::IDX_VWIN && vmap[slot]) begin // R21 R22
      unique case (entry)
        2'h0: res = gp_pkg::IDX_DRV;
        2'h1: res = gp_pkg::IDX_LVL;
        2'h2: res = gp_pkg::IDX_IN;
        2'h3: res = gp_pkg::IDX_IRQ_FLG;
      endcase
    end
    return res;
  endfunction

  function automatic logic is_mapped(input logic [5:0] idx);
    return (idx <= gp_pkg::IDX_IRQ_SEL) || (idx == gp_pkg::IDX_IRQ_FLG) ||
           (idx >= gp_pkg::IDX_PIN_CFG && idx < gp_pkg::IDX_PIN_CFG + 6'h08) ||
           (idx >= gp_pkg::IDX_MULTI && idx <= gp_pkg::IDX_CKEV);
  endfunction

  // Set, clear, flip or plain store chosen by the alias offset
  function automatic logic [7:0] alias_write(
    input logic [7:0] cur,
    input logic [7:0] d,
    input logic [1:0] op
  );
    logic [7:0] res;
    res = d;
    unique case (op)
      2'h0: res = d;
      2'h1: res = cur | d;  // R2 R8
      2'h2: res = cur & ~d; // R3 R9
      2'h3: res = cur ^ d;  // R4 R10
    endcase
    return res;
  endfunction

  function automatic logic [7:0] read_reg(input gp_pkg::gp_state_s s, input logic [5:0] idx);
    logic [7:0] res;
    res = gp_pkg::RST_BYTE;
    if (idx <= gp_pkg::IDX_DRV_FLIP) begin
      res = s.drv; // R5
    end else if (idx <= gp_pkg::IDX_LVL_FLIP) begin
      res = s.lvl; // R11
    end else if (idx == gp_pkg::IDX_IN) begin
      res = s.in_val; // R12
    end else if (idx == gp_pkg::IDX_IRQ_CTL) begin
      res = {6'h00, s.irq_lvl_cfg}; // R23
    end else if (idx == gp_pkg::IDX_IRQ_SEL) begin
      res = s.irq_sel;
    end else if (idx == gp_pkg::IDX_IRQ_FLG) begin
      res = s.flags;
    end else if (idx >= gp_pkg::IDX_PIN_CFG && idx < gp_pkg::IDX_PIN_CFG + 6'h08) begin
      res = {1'b0, s.cfg[idx[2:0]][6:0]};
    end else if (idx == gp_pkg::IDX_MULTI) begin
      res = s.multi;
    end else if (idx == gp_pkg::IDX_VMAP) begin
      res = {4'h0, s.vmap};
    end else if (idx == gp_pkg::IDX_CKEV) begin
      res = {3'h0, s.ckev};
    end
    return res;
  endfunction

  logic [5:0] aw_idx_in;
  logic [5:0] ar_idx_in;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic       do_wr;
  logic       bad_wr;

  assign aw_idx_in = s_axi_awaddr[7:2];
  assign ar_idx_in = s_axi_araddr[7:2];

  always_comb begin
    gp_pkg::gp_state_s n;
    logic       nv;
    logic       ov;
    logic       hit;
    logic       v;
    logic [2:0] ck_pin;
    n        = st_reg;
    nv       = 1'b0;
    ov       = 1'b0;
    hit      = 1'b0;
    v        = 1'b0;
    ck_pin   = 3'h0;
    flag_set = 8'h00;
    flag_clr = 8'h00;
    wr_idx   = map_index(st_reg.aw_idx, st_reg.vmap);
    rd_idx   = map_index(ar_idx_in, st_reg.vmap);
    do_wr    = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
    bad_wr   = !is_mapped(wr_idx);

    // Write address and data are taken independently
    if (s_axi_awvalid && st_reg.awready) begin
      n.aw_have = 1'b1;
      n.aw_idx  = aw_idx_in;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      n.w_have = 1'b1;
      n.wdata  = s_axi_wdata[7:0];
      n.wlane0 = s_axi_wstrb[0];
    end

    if (do_wr) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = bad_wr ? gp_pkg::RESP_SLVERR : gp_pkg::RESP_OKAY;
      if (st_reg.wlane0 && !bad_wr) begin
        if (wr_idx <= gp_pkg::IDX_DRV_FLIP) begin
          n.drv = alias_write(st_reg.drv, st_reg.wdata, wr_idx[1:0]); // R1
        end else if (wr_idx <= gp_pkg::IDX_LVL_FLIP) begin
          n.lvl = alias_write(st_reg.lvl, st_reg.wdata, wr_idx[1:0]); // R6
        end else if (wr_idx == gp_pkg::IDX_IRQ_CTL) begin
          n.irq_lvl_cfg = st_reg.wdata[1:0] & gp_pkg::IRQ_LVL_MASK_W; // R14 R23
        end else if (wr_idx == gp_pkg::IDX_IRQ_SEL) begin
          n.irq_sel = st_reg.wdata;
        end else if (wr_idx == gp_pkg::IDX_IRQ_FLG) begin
          flag_clr = st_reg.wdata; // R17
        end else if (wr_idx >= gp_pkg::IDX_PIN_CFG && wr_idx < gp_pkg::IDX_MULTI) begin
          for (int i = 0; i < gp_pkg::PINS; i++) begin
            if ((st_reg.multi == 8'h00) ? (wr_idx[2:0] == 3'(i)) : st_reg.multi[i]) begin // R20
              n.cfg[i] = {1'b0, st_reg.wdata[6:0]};
            end
          end
        end else if (wr_idx == gp_pkg::IDX_MULTI) begin
          n.multi = st_reg.wdata;
        end else if (wr_idx == gp_pkg::IDX_VMAP) begin
          n.vmap = st_reg.wdata[3:0]; // R22
        end else if (wr_idx == gp_pkg::IDX_CKEV) begin
          n.ckev = st_reg.wdata[4:0];
        end
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // Read is answered one cycle after the address is taken
    if (s_axi_arvalid && st_reg.arready) begin
      n.rvalid = 1'b1;
      n.rdata  = read_reg(st_reg, rd_idx);
      n.rresp  = is_mapped(rd_idx) ? gp_pkg::RESP_OKAY : gp_pkg::RESP_SLVERR;
    end else if (st_reg.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end

    // Three-stage synchroniser; a level counts once stages two and three agree
    n.sync1 = pin_i;
    n.sync2 = st_reg.sync1;
    n.sync3 = st_reg.sync2;
    for (int i = 0; i < gp_pkg::PINS; i++) begin
      ov  = st_reg.in_val[i];
      nv  = ov;
      hit = 1'b0;
      if (st_reg.cfg[i].isc == gp_pkg::ISC_OFF) begin
        nv = 1'b0; // R13
      end else if (st_reg.sync2[i] == st_reg.sync3[i]) begin
        nv = st_reg.sync3[i] ^ st_reg.cfg[i].inven; // R12
      end
      n.in_val[i] = nv;
      if (st_reg.cfg[i].isc != gp_pkg::ISC_OFF) begin
        unique case (st_reg.cfg[i].isc)
          gp_pkg::ISC_BOTH,
          gp_pkg::ISC_FORCE: hit = nv != ov;
          gp_pkg::ISC_RISE:  hit = nv && !ov;
          gp_pkg::ISC_FALL:  hit = !nv && ov;
          gp_pkg::ISC_LOW:   hit = !nv;
          default:           hit = 1'b0;
        endcase
      end
      flag_set[i] = hit && st_reg.irq_sel[i]; // R16 R17
    end
    // A new sense hit outranks a clear in the same cycle
    n.flags = (st_reg.flags & ~flag_clr) | flag_set; // R17

    n.irq_req   = (n.irq_lvl_cfg != 2'h0) && (n.flags != 8'h00); // R14
    n.irq_level = n.irq_req ? n.irq_lvl_cfg : 2'h0;

    // Clock out is a flop toggle, so it runs at half the bus clock
    n.clk_tog = !st_reg.clk_tog; // R18
    n.ev_q    = event_ch0;       // R19
    ck_pin    = n.ckev[gp_pkg::CKEV_PIN_LSB +: 3];
    for (int i = 0; i < gp_pkg::PINS; i++) begin
      v = n.lvl[i] ^ n.cfg[i].inven;
      n.pin_o[i]  = v;
      n.pin_oe[i] = n.drv[i]; // R1 R7
      if (n.cfg[i].opc[gp_pkg::OPC_WIRED_BIT]) begin
        // Wired modes release the pin for the level the pull provides
        n.pin_oe[i] = n.drv[i] && (n.cfg[i].opc[gp_pkg::OPC_AND_BIT] ? !v : v); // R7
      end
      if (ck_pin == 3'(i)) begin
        if (n.ckev[gp_pkg::CKEV_CLK_BIT]) begin
          n.pin_o[i]  = n.clk_tog; // R18
          n.pin_oe[i] = 1'b1;
        end else if (n.ckev[gp_pkg::CKEV_EV_BIT]) begin
          n.pin_o[i]  = n.ev_q; // R19
          n.pin_oe[i] = 1'b1;
        end
      end
    end

    n.awready = !n.aw_have && !n.bvalid;
    n.wready  = !n.w_have && !n.bvalid;
    n.arready = !n.rvalid;
    st_next   = n;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready  = st_reg.wready;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rresp   = st_reg.rresp;
  assign s_axi_rdata   = {24'h000000, st_reg.rdata};
  assign pin_o         = st_reg.pin_o;
  assign pin_oe        = st_reg.pin_oe;
  assign irq_req       = st_reg.irq_req;
  assign irq_level     = st_reg.irq_level;

endmodule
`default_nettype wire

/* File: gp_port_regs_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module gp_port_regs_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq_req,
  input wire logic [1:0]  irq_level
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_answer;
    ##2 s_axi_bvalid && !s_axi_awready;
  endsequence
  AST_WR_ANSWER: assert property (s_wr_taken |-> s_b_answer)
    else $error("write answer not in time");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  AST_BUSY_NO_TAKE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not in time");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read upper bytes not zero");
  AST_IRQ_QUIET: assert property (!irq_req |-> irq_level == 2'h0)
    else $error("level shown without request");
  AST_IRQ_ACTIVE: assert property (irq_req |-> irq_level != 2'h0)
    else $error("request without level");
endmodule
bind gp_port_regs gp_port_regs_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_req, .irq_level);
`default_nettype wire

/* File: gp_port_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module gp_port_regs_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00, ext = 8'h3c, pin_i, pin_o, pin_oe;
  logic [31:0] wd = 32'h0, rdata;
  logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, ev = 1'b0;
  logic        awr, wrr, bv, arr, rv, irq, b;
  logic [1:0]  bresp, rresp, lvl;
  int          bad_count = 0, total_checks = 0, cyc = 0;
  always #4 aclk = ~aclk;
  gp_port_regs u_dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .pin_i, .pin_o, .pin_oe, .event_ch0(ev), .irq_req(irq),
    .irq_level(lvl));
  gp_pins_model u_pins (.pin_o, .pin_oe, .ext_lvl(ext), .pin_i);
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Each access starts one edge on, so no signal is assigned twice in a step
  task automatic wr(input logic [5:0] ix, input logic [7:0] d,
                    input logic [1:0] er = gp_pkg::RESP_OKAY);
    @(posedge aclk);
    awa <= {ix, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
    end while (bv !== 1'b1);
    brdy <= 1'b0;
    chk("bresp", {6'h0, er}, {6'h0, bresp});
  endtask
  task automatic rd(input logic [5:0] ix, input logic [7:0] e,
                    input logic [1:0] er = gp_pkg::RESP_OKAY);
    @(posedge aclk);
    ara <= {ix, 2'h0};
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rrdy <= 1'b0;
    chk("rdata", e, rdata[7:0]);
    chk("rresp", {6'h0, er}, {6'h0, rresp});
  endtask
  task automatic note(input int n);
    $display("test %0d done", n);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Tests need well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      if (i != 8) rd(i[5:0], 8'h00);
    end
    rd(6'h0b, 8'h00, gp_pkg::RESP_SLVERR);
    note(1);
    wr(6'h00, 8'ha5);
    wr(6'h01, 8'h0f);
    rd(6'h00, 8'haf);
    wr(6'h02, 8'h81);
    rd(6'h00, 8'h2e);
    wr(6'h03, 8'hff);
    for (int i = 0; i < 4; i++) rd(i[5:0], 8'hd1);
    chk("pin_oe", 8'hd1, pin_oe);
    note(2);
    wr(6'h04, 8'h5a);
    wr(6'h05, 8'h03);
    rd(6'h04, 8'h5b);
    wr(6'h06, 8'h42);
    rd(6'h04, 8'h19);
    wr(6'h07, 8'hf0);
    for (int i = 4; i < 8; i++) rd(i[5:0], 8'he9);
    chk("pin_o", 8'hc1, pin_o & pin_oe);
    repeat (4) @(posedge aclk);
    rd(6'h08, 8'hed);
    wr(6'h00, 8'h00);
    note(3);
    wr(6'h12, 8'h07);
    wr(6'h20, 8'h30);
    wr(6'h10, 8'h07);
    rd(6'h14, 8'h07);
    rd(6'h15, 8'h07);
    rd(6'h10, 8'h00);
    rd(6'h08, 8'h08);
    wr(6'h20, 8'h34);
    wr(6'h10, 8'h00);
    wr(6'h20, 8'h00);
    rd(6'h12, 8'h00);
    note(4);
    wr(6'h09, 8'h02);
    rd(6'h09, 8'h02);
    wr(6'h0a, 8'h01);
    ext <= 8'h7d;
    repeat (6) @(posedge aclk);
    chk("irq_req", 8'h01, {7'h0, irq});
    chk("irq_level", 8'h02, {6'h0, lvl});
    rd(6'h0c, 8'h01);
    wr(6'h0c, 8'h01);
    rd(6'h0c, 8'h00);
    chk("irq_req", 8'h00, {7'h0, irq});
    note(5);
    wr(6'h21, 8'h0f);
    for (int s = 0; s < 4; s++) begin
      wr({2'h3, s[1:0], 2'h0}, {6'h04, s[1:0]});
      rd(6'h00, {6'h04, s[1:0]});
    end
    wr(6'h21, 8'h07);
    wr(6'h3c, 8'hff, gp_pkg::RESP_SLVERR);
    rd(6'h00, 8'h13);
    wr(6'h00, 8'h00);
    note(6);
    wr(6'h22, 8'h0e);
    ev <= 1'b1;
    @(posedge aclk);
    ev <= 1'b0;
    @(posedge aclk);
    chk("event_pin", 8'h03, {6'h0, pin_oe[3], pin_o[3]});
    @(posedge aclk);
    chk("event_pin", 8'h02, {6'h0, pin_oe[3], pin_o[3]});
    wr(6'h22, 8'h0d);
    b = pin_o[3];
    @(posedge aclk);
    chk("clock_pin", {7'h0, ~b}, {7'h0, pin_o[3]});
    note(7);
    wr(6'h22, 8'h00);
    wr(6'h11, 8'h01);
    wr(6'h12, 8'h02);
    wr(6'h0a, 8'h06);
    // Pin one rises and pin two falls; each sense code sees only its own edge
    ext <= 8'h7b;
    repeat (6) @(posedge aclk);
    rd(6'h0c, 8'h06);
    wr(6'h0c, 8'h06);
    ext <= 8'h7d;
    repeat (6) @(posedge aclk);
    rd(6'h0c, 8'h00);
    wr(6'h16, 8'h43);
    rd(6'h08, 8'h3d);
    wr(6'h0a, 8'h40);
    // Low level keeps setting the flag, so the clear loses
    wr(6'h0c, 8'h40);
    rd(6'h0c, 8'h40);
    chk("irq_req", 8'h01, {7'h0, irq});
    wr(6'h0a, 8'h00);
    wr(6'h0c, 8'hff);
    rd(6'h0c, 8'h00);
    wr(6'h17, 8'h28);
    wr(6'h01, 8'h80);
    chk("pin_oe", 8'h00, pin_oe);
    wr(6'h06, 8'h80);
    chk("pin_oe", 8'h80, pin_oe);
    chk("pin_o", 8'h00, pin_o & pin_oe);
    rd(6'h31, 8'h69);
    wr(6'h00, 8'h00);
    note(8);
    close_out();
  end
endmodule
`default_nettype wire
